// ### logic/rail_fault_manager.sv
// Function
// (RULE_01) watch V, I, T, turn-on time limits
// (RULE_02) fault event: alert, log, status, respond; code logs one event per cycle and responds to the lowest-numbered type only
// (RULE_03) per-type glitch filter, enable and duration
// (RULE_04) action: log, shut now, shut delayed
// (RULE_05) no-restart keeps rail off until command
// (RULE_06) limited retry up to 14, then off
// (RULE_07) continuous retry until commanded off
// (RULE_08) re-sequence after retries run out
// (RULE_09) inputs: 12-bit converter and digital monitors
// (RULE_10) all voltage channels scanned every 400 us
// (RULE_11) current channel slot of 200 us
// (RULE_12) temperature channel slot of 4.17 ms
// (RULE_13) compare each result with its thresholds
// (RULE_14) input pin faults only when enabled
// (RULE_15) input faults: no limited retry
// (RULE_16) fault shutdown drops slaves, no cascade
// (RULE_17) re-sequence held while input fault present
// (RULE_18) one common gap between restart attempts
// (RULE_19) unfiltered fault acts on first crossing
// (RULE_20) restart uses normal dependencies and delays
`timescale 1ns/10ps
module rail_fault_manager import rail_fault_pkg::*; #(
  parameter int T_SLOT_CYC_P = T_SLOT_CYC
) (
  // clock and reset
  input  wire logic                                   i_clk_sys,
  input  wire logic                                   i_rst_n,
  // pins from outside
  input  wire logic [NUM_RAILS-1:0]                   i_gpi,
  input  wire logic [NUM_DIGITAL_MONITOR_INPUT-1:0]                    i_digital_monitor_input,
  // converter
  output conv_req_s                                   o_conv,
  input  wire conv_res_s                              i_conv,
  // configuration
  input  wire fault_cfg_s [NUM_FT-1:0]                i_fault_cfg,
  input  wire rail_limit_s [NUM_RAILS-1:0]            i_limits,
  input  wire rail_ctl_s [NUM_RAILS-1:0]              i_rail_ctl,
  input  wire logic [NUM_RAILS-1:0]                   i_input_fault_enable,
  input  wire logic [NUM_RAILS-1:0][NUM_RAILS-1:0]    i_slave_mask,
  input  wire logic [15:0]                            i_restart_gap,
  // commands
  input  wire logic [NUM_RAILS-1:0]                   i_on_cmd,
  input  wire logic                                   i_fault_clr,
  input  wire logic                                   i_status_clr,
  input  wire logic                                   i_alert_clr,
  // results
  output logic [NUM_RAILS-1:0]                        o_en,
  output logic                                        o_alert_n,
  output log_s                                        o_log,
  output logic [NUM_RAILS-1:0][NUM_FT-1:0]            o_status,
  output logic [NUM_RAILS-1:0]                        o_reseq_wait
);
  typedef struct packed {
    logic [SYNC_W-1:0]                  sync1;
    logic [SYNC_W-1:0]                  sync2;
    logic [SYNC_W-1:0]                  sync3;
    logic [SYNC_W-1:0]                  lvl;
    logic [9:0]                         tick_cnt;
    logic                               tick;
    logic [7:0]                         v_cnt;
    logic [10:0]                        i_cnt;
    logic [15:0]                        t_cnt;
    logic [4:0]                         v_ch;
    logic [4:0]                         i_ch;
    logic [4:0]                         t_ch;
    logic                               pend_v;
    logic                               pend_i;
    logic                               pend_t;
    conv_req_s                          req;
    logic [NUM_RAILS-1:0][NUM_FT-1:0]   upd;
    logic [NUM_RAILS-1:0][NUM_FT-1:0]   flt;
    logic                               alert;
    log_s                               log;
  } mgr_s;

  mgr_s                    state;
  mgr_s                    next_state;
  logic [NUM_RAILS-1:0]    rail_event;
  logic [NUM_RAILS-1:0][2:0] rail_ft;
  logic [NUM_RAILS-1:0]    fault_shut;
  logic [NUM_RAILS-1:0]    gpi_shut;
  logic [NUM_RAILS-1:0]    slave_kill;
  logic                    reseq_hold;
  logic                    reseq_go;

  always_comb begin
    int          r;
    rail_limit_s lim;
    r = 0;
    lim = '0;
    next_state = state;
    // pins pass three flops; a change is taken once the last two agree
    next_state.sync1 = {i_digital_monitor_input, i_gpi};
    next_state.sync2 = state.sync1;
    next_state.sync3 = state.sync2;
    next_state.lvl = (state.sync3 & ~(state.sync2 ^ state.sync3)) | (state.lvl & (state.sync2 ^ state.sync3));
    next_state.tick = (state.tick_cnt == 10'(TICK_CYC - 1));
    next_state.tick_cnt = next_state.tick ? 10'h000 : state.tick_cnt + 10'h001;
    next_state.upd = '0;
    next_state.flt = '0;
    // (RULE_14) input pin fault only when enabled
    for (int i = 0; i < NUM_RAILS; i++) begin
      next_state.upd[i][FT_GPI] = 1'b1;
      next_state.flt[i][FT_GPI] = state.lvl[i] && i_input_fault_enable[i];
    end
    // (RULE_10) voltage slot, 32 channels per scan
    next_state.v_cnt = (state.v_cnt == 8'(V_SLOT_CYC - 1)) ? 8'h00 : state.v_cnt + 8'h01;
    if (state.v_cnt == 8'(V_SLOT_CYC - 1)) begin
      // (RULE_09) digital monitors judged from their pins
      if (state.v_ch >= 5'(DIGITAL_MONITOR_INPUT_BASE)) begin
        r = int'(state.v_ch);
        next_state.upd[r][FT_UV] = 1'b1;
        next_state.flt[r][FT_UV] = !state.lvl[r + NUM_DIGITAL_MONITOR_INPUT];
        next_state.v_ch = state.v_ch + 5'h01;
      end else
        next_state.pend_v = 1'b1;
    end
    // (RULE_11) current slot
    next_state.i_cnt = (state.i_cnt == 11'(I_SLOT_CYC - 1)) ? 11'h000 : state.i_cnt + 11'h001;
    if (state.i_cnt == 11'(I_SLOT_CYC - 1))
      next_state.pend_i = 1'b1;
    // (RULE_12) temperature slot
    next_state.t_cnt = (state.t_cnt == 16'(T_SLOT_CYC_P - 1)) ? 16'h0000 : state.t_cnt + 16'h0001;
    if (state.t_cnt == 16'(T_SLOT_CYC_P - 1))
      next_state.pend_t = 1'b1;
    // one conversion request per cycle, voltage first
    next_state.req.valid = 1'b0;
    if (state.pend_v) begin
      next_state.req = '{valid: 1'b1, kind: K_VOLT, chan: state.v_ch};
      next_state.pend_v = 1'b0;
      next_state.v_ch = state.v_ch + 5'h01;
    end else if (state.pend_i) begin
      next_state.req = '{valid: 1'b1, kind: K_CURR, chan: state.i_ch};
      next_state.pend_i = 1'b0;
      next_state.i_ch = state.i_ch + 5'h01;
    end else if (state.pend_t) begin
      next_state.req = '{valid: 1'b1, kind: K_TEMP, chan: state.t_ch};
      next_state.pend_t = 1'b0;
      next_state.t_ch = state.t_ch + 5'h01;
    end
    // (RULE_13) compare each result with its channel limits
    // (RULE_01) crossing raises a raw fault
    if (i_conv.valid) begin
      r = int'(i_conv.chan);
      lim = i_limits[r];
      case (i_conv.kind)
        K_VOLT: begin
          next_state.upd[r][FT_OV] = 1'b1;
          next_state.flt[r][FT_OV] = i_conv.data > lim.ov;
          next_state.upd[r][FT_UV] = 1'b1;
          next_state.flt[r][FT_UV] = i_conv.data < lim.uv;
        end
        K_CURR: begin
          next_state.upd[r][FT_OC] = 1'b1;
          next_state.flt[r][FT_OC] = i_conv.data > lim.oc;
        end
        K_TEMP: begin
          next_state.upd[r][FT_OT] = 1'b1;
          next_state.flt[r][FT_OT] = i_conv.data > lim.ot;
        end
        default: begin
          next_state.upd[r] = '0;
        end
      endcase
    end
    // (RULE_02) alert on every fault event, log only the lowest-numbered rail's event per cycle
    next_state.alert = (|rail_event) || (state.alert && !i_alert_clr);
    next_state.log = '0;
    for (int i = NUM_RAILS - 1; i >= 0; i--) begin
      if (rail_event[i])
        next_state.log = '{valid: 1'b1, rail: 5'(i), ftype: rail_ft[i]};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      state <= '0;
    else
      state <= next_state;
  end

  // (RULE_16) only a rail's own fault shutdown drops its slaves
  always_comb begin
    slave_kill = '0;
    for (int i = 0; i < NUM_RAILS; i++) begin
      for (int j = 0; j < NUM_RAILS; j++) begin
        if (fault_shut[i] && i_slave_mask[i][j])
          slave_kill[j] = 1'b1;
      end
    end
  end

  // (RULE_17) hold re-sequence while an input fault is present
  assign reseq_hold = |(o_reseq_wait & gpi_shut & state.lvl[NUM_RAILS-1:0]);
  assign reseq_go   = (|o_reseq_wait) && !reseq_hold;

  for (genvar g = 0; g < NUM_RAILS; g++) begin : g_rail
    rail_fault_unit u_rail (
      .i_clk_sys     (i_clk_sys),
      .i_rst_n       (i_rst_n),
      .i_tick        (state.tick),
      .i_upd         (state.upd[g]),
      .i_flt         (state.flt[g]),
      .i_cfg         (i_fault_cfg),
      .i_ctl         (i_rail_ctl[g]),
      .i_restart_gap (i_restart_gap),
      .i_on_cmd      (i_on_cmd[g]),
      .i_slave_kill  (slave_kill[g]),
      .i_fault_clr   (i_fault_clr),
      .i_status_clr  (i_status_clr),
      .i_reseq_go    (reseq_go),
      .o_en          (o_en[g]),
      .o_event       (rail_event[g]),
      .o_event_ft    (rail_ft[g]),
      .o_fault_shut  (fault_shut[g]),
      .o_gpi_shut    (gpi_shut[g]),
      .o_reseq_wait  (o_reseq_wait[g]),
      .o_status      (o_status[g])
    );
  end

  assign o_conv    = state.req;
  assign o_alert_n = !state.alert;
  assign o_log     = state.log;

  chk_alert_on_event: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_02
    (|rail_event) |=> !o_alert_n)
    else $error("alert not raised on fault event");
  chk_log_on_event: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_02
    (|rail_event) |=> (o_log.valid && (!$past(rail_event[0]) ||
                       (o_log.rail == 5'h00 && o_log.ftype == $past(rail_ft[0])))))
    else $error("fault event not logged");
  chk_vslot_request: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_10
    (state.v_cnt == 8'(V_SLOT_CYC - 1) && state.v_ch < 5'(DIGITAL_MONITOR_INPUT_BASE))
    |-> ##[2:3] (o_conv.valid && o_conv.kind == K_VOLT))
    else $error("voltage slot without conversion request");
  chk_slave_drop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_16
    (|slave_kill) |=> ((o_en & $past(slave_kill) & ~rail_event) == '0))
    else $error("slave rail kept on after master fault");
  chk_reseq_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_17
    (|(o_reseq_wait & gpi_shut & state.lvl[NUM_RAILS-1:0]))
    |=> ((o_reseq_wait & $past(o_reseq_wait)) == $past(o_reseq_wait)))
    else $error("re-sequence left while input fault present");
endmodule

// ### logic/rail_fault_pkg.sv
package rail_fault_pkg;
  localparam int NUM_RAILS       = 32;
  localparam int NUM_FT          = 6;
  localparam int ADC_W           = 12;
  localparam int NUM_DIGITAL_MONITOR_INPUT        = 8;
  localparam int DIGITAL_MONITOR_INPUT_BASE       = NUM_RAILS - NUM_DIGITAL_MONITOR_INPUT;
  localparam int SYNC_W          = NUM_RAILS + NUM_DIGITAL_MONITOR_INPUT;
  localparam int MAX_RETRY       = 14;
  // timing, clock period and times in ns
  localparam int CLK_PERIOD_NS   = 100;
  localparam int VSCAN_PERIOD_NS = 400000;
  localparam int V_SLOT_CYC      = VSCAN_PERIOD_NS / CLK_PERIOD_NS / NUM_RAILS;
  localparam int I_SLOT_NS       = 200000;
  localparam int I_SLOT_CYC      = I_SLOT_NS / CLK_PERIOD_NS;
  localparam int T_SLOT_NS       = 4170000;
  localparam int T_SLOT_CYC      = T_SLOT_NS / CLK_PERIOD_NS;
  localparam int TICK_NS         = 100000;
  localparam int TICK_CYC        = TICK_NS / CLK_PERIOD_NS;
  // fault type index
  localparam int FT_OV           = 0;
  localparam int FT_UV           = 1;
  localparam int FT_OC           = 2;
  localparam int FT_OT           = 3;
  localparam int FT_TON          = 4;
  localparam int FT_GPI          = 5;

  typedef enum logic [1:0] {ACT_LOG, ACT_SHUT_NOW, ACT_SHUT_DELAY} action_e;
  typedef enum logic [1:0] {RST_NONE, RST_LIMITED, RST_CONT} restart_e;
  typedef enum logic [1:0] {K_VOLT, K_CURR, K_TEMP} conv_kind_e;

  typedef struct packed {
    logic        filt_en;
    logic [15:0] filt_ticks;
    action_e     act;
    restart_e    rst;
    logic [3:0]  retries;
    logic        reseq;
  } fault_cfg_s;

  typedef struct packed {
    logic [ADC_W-1:0] ov;
    logic [ADC_W-1:0] uv;
    logic [ADC_W-1:0] oc;
    logic [ADC_W-1:0] ot;
  } rail_limit_s;

  typedef struct packed {
    logic        on_ctl;
    logic        deps_ok;
    logic        pg;
    logic [15:0] on_delay;
    logic [15:0] off_delay;
    logic [15:0] ton_max;
  } rail_ctl_s;

  typedef struct packed {
    logic       valid;
    conv_kind_e kind;
    logic [4:0] chan;
  } conv_req_s;

  typedef struct packed {
    logic             valid;
    conv_kind_e       kind;
    logic [4:0]       chan;
    logic [ADC_W-1:0] data;
  } conv_res_s;

  typedef struct packed {
    logic       valid;
    logic [4:0] rail;
    logic [2:0] ftype;
  } log_s;
endpackage

// ### logic/rail_fault_unit.sv
`timescale 1ns/10ps
module rail_fault_unit import rail_fault_pkg::*; (
  // clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_tick,
  // compare results
  input  wire logic [NUM_FT-1:0]      i_upd,
  input  wire logic [NUM_FT-1:0]      i_flt,
  // configuration and control
  input  wire fault_cfg_s [NUM_FT-1:0] i_cfg,
  input  wire rail_ctl_s              i_ctl,
  input  wire logic [15:0]            i_restart_gap,
  input  wire logic                   i_on_cmd,
  input  wire logic                   i_slave_kill,
  input  wire logic                   i_fault_clr,
  input  wire logic                   i_status_clr,
  input  wire logic                   i_reseq_go,
  // results
  output logic                        o_en,
  output logic                        o_event,
  output logic [2:0]                  o_event_ft,
  output logic                        o_fault_shut,
  output logic                        o_gpi_shut,
  output logic                        o_reseq_wait,
  output logic [NUM_FT-1:0]           o_status
);
  typedef enum logic [2:0] {M_OFF, M_ON_WAIT, M_ON, M_OFF_DELAY, M_FAULT_OFF, M_GAP, M_LOCKED, M_RESEQ} rail_mode_e;
  typedef struct packed {
    rail_mode_e                 mode;
    logic                       en;
    logic [NUM_FT-1:0][15:0]    fcnt;
    logic [NUM_FT-1:0]          fnow;
    logic [NUM_FT-1:0]          status;
    logic [15:0]                tcnt;
    logic [3:0]                 tries;
    logic                       retrying;
    logic                       lat_gpi;
    restart_e                   lat_rst;
    logic                       lat_reseq;
    logic                       lat_exh;
    logic                       event_p;
    logic [2:0]                 event_ft;
    logic                       fault_shut;
  } unit_s;

  unit_s             state;
  unit_s             next_state;
  logic [NUM_FT-1:0] confirm;
  logic [2:0]        ft;

  function automatic rail_mode_e after_shut(restart_e rst, logic general_input_pin, logic reseq, logic exh);
    logic lim;
    lim = (rst == RST_LIMITED) && !general_input_pin;
    if (rst == RST_CONT || (lim && !exh))
      return M_GAP;
    if (reseq)
      return M_RESEQ;
    return lim ? M_LOCKED : M_FAULT_OFF;
  endfunction

  always_comb begin
    logic [NUM_FT-1:0] upd;
    logic [NUM_FT-1:0] flt;
    logic [3:0]        lim;
    logic              exh;
    fault_cfg_s        c;
    c = '0;
    lim = 4'h0;
    exh = 1'b0;
    next_state = state;
    next_state.event_p = 1'b0;
    next_state.fault_shut = 1'b0;
    upd = i_upd;
    flt = i_flt;
    upd[FT_TON] = 1'b1;
    flt[FT_TON] = (state.mode == M_ON) && !i_ctl.pg && (state.tcnt >= i_ctl.ton_max);
    for (int k = 0; k < NUM_FT; k++) begin
      // (RULE_03) per-type glitch filter
      // (RULE_19) unfiltered acts on first crossing
      if (i_cfg[k].filt_en && i_cfg[k].filt_ticks != 16'h0000)
        confirm[k] = i_tick && state.fnow[k] && (state.fcnt[k] == i_cfg[k].filt_ticks - 16'h0001);
      else
        confirm[k] = upd[k] && flt[k] && !state.fnow[k];
      if (upd[k])
        next_state.fnow[k] = flt[k];
      if (!state.fnow[k])
        next_state.fcnt[k] = 16'h0000;
      else if (i_tick && state.fcnt[k] != 16'hFFFF)
        next_state.fcnt[k] = state.fcnt[k] + 16'h0001;
    end
    ft = 3'h0;
    for (int k = NUM_FT - 1; k >= 0; k--) begin
      if (confirm[k])
        ft = 3'(k);
    end
    c = i_cfg[ft];
    lim = (c.retries > 4'(MAX_RETRY)) ? 4'(MAX_RETRY) : c.retries;
    exh = state.retrying ? (state.tries + 4'h1 >= lim) : (lim == 4'h0);
    // (RULE_02) status set wins over clear
    next_state.status = confirm | (state.status & {NUM_FT{!i_status_clr}});
    next_state.event_p = |confirm;
    next_state.event_ft = ft;
    case (state.mode)
      M_OFF: begin
        if (i_on_cmd) begin
          next_state.mode = M_ON_WAIT;
          next_state.tcnt = 16'h0000;
          next_state.tries = 4'h0;
          next_state.retrying = 1'b0;
        end
      end
      // (RULE_20) restart via dependencies and on delay
      M_ON_WAIT: begin
        if (!i_ctl.on_ctl)
          next_state.mode = M_OFF;
        else if (i_ctl.deps_ok && state.tcnt >= i_ctl.on_delay) begin
          next_state.mode = M_ON;
          next_state.en = 1'b1;
          next_state.tcnt = 16'h0000;
        end else if (i_ctl.deps_ok && i_tick)
          next_state.tcnt = state.tcnt + 16'h0001;
      end
      M_ON: begin
        if (!i_ctl.on_ctl) begin
          next_state.mode = M_OFF;
          next_state.en = 1'b0;
        end else if (i_tick && !i_ctl.pg && state.tcnt != 16'hFFFF)
          next_state.tcnt = state.tcnt + 16'h0001;
      end
      // (RULE_04) shut down after off delay
      M_OFF_DELAY: begin
        if (state.tcnt >= i_ctl.off_delay) begin
          next_state.en = 1'b0;
          next_state.fault_shut = 1'b1;
          next_state.tcnt = 16'h0000;
          next_state.mode = after_shut(state.lat_rst, state.lat_gpi, state.lat_reseq, state.lat_exh);
          if (state.retrying && state.lat_rst == RST_LIMITED)
            next_state.tries = state.tries + 4'h1;
        end else if (i_tick)
          next_state.tcnt = state.tcnt + 16'h0001;
      end
      // (RULE_05) stays off until fresh turn-on
      M_FAULT_OFF: begin
        if (i_on_cmd) begin
          next_state.mode = M_ON_WAIT;
          next_state.tcnt = 16'h0000;
          next_state.tries = 4'h0;
          next_state.retrying = 1'b0;
        end
      end
      // (RULE_18) common gap between restarts
      // (RULE_07) continuous retry until commanded off
      M_GAP: begin
        if (state.lat_rst == RST_CONT && !i_ctl.on_ctl)
          next_state.mode = M_OFF;
        else if (state.tcnt >= i_restart_gap) begin
          next_state.mode = M_ON_WAIT;
          next_state.retrying = 1'b1;
          next_state.tcnt = 16'h0000;
        end else if (i_tick)
          next_state.tcnt = state.tcnt + 16'h0001;
      end
      // (RULE_06) retries exhausted, off until cleared
      M_LOCKED: begin
        if (i_fault_clr)
          next_state.mode = M_OFF;
      end
      // (RULE_08) wait for re-sequence start
      M_RESEQ: begin
        if (i_reseq_go) begin
          next_state.mode = M_ON_WAIT;
          next_state.tcnt = 16'h0000;
          next_state.tries = 4'h0;
          next_state.retrying = 1'b0;
        end
      end
      default: begin
        next_state.mode = M_OFF;
        next_state.en = 1'b0;
      end
    endcase
    // (RULE_16) master shutdown forces this rail off
    if (i_slave_kill && (state.mode == M_ON_WAIT || state.mode == M_ON ||
                         state.mode == M_OFF_DELAY || state.mode == M_GAP)) begin
      next_state.mode = M_OFF;
      next_state.en = 1'b0;
    end
    // (RULE_04) selected action on confirmed fault
    // (RULE_15) input-pin faults never use limited retry
    if (|confirm && c.act != ACT_LOG && (state.mode == M_ON_WAIT || state.mode == M_ON)) begin
      next_state.lat_rst = c.rst;
      next_state.lat_gpi = (ft == 3'(FT_GPI));
      next_state.lat_reseq = c.reseq;
      next_state.lat_exh = exh;
      next_state.tcnt = 16'h0000;
      if (c.act == ACT_SHUT_NOW) begin
        next_state.en = 1'b0;
        next_state.fault_shut = 1'b1;
        next_state.mode = after_shut(c.rst, ft == 3'(FT_GPI), c.reseq, exh);
        if (state.retrying && c.rst == RST_LIMITED)
          next_state.tries = state.tries + 4'h1;
      end else
        next_state.mode = M_OFF_DELAY;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign o_en         = state.en;
  assign o_event      = state.event_p;
  assign o_event_ft   = state.event_ft;
  assign o_fault_shut = state.fault_shut;
  assign o_gpi_shut   = state.lat_gpi;
  assign o_reseq_wait = (state.mode == M_RESEQ);
  assign o_status     = state.status;

  chk_no_restart_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_05
    (state.mode == M_FAULT_OFF && !i_on_cmd) |=> (state.mode == M_FAULT_OFF && !state.en))
    else $error("rail left fault-off without turn-on");
  chk_retry_cap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_06
    state.tries <= 4'(MAX_RETRY))
    else $error("retry count above limit");
  chk_gpi_no_limited: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_15
    (state.mode == M_GAP && state.lat_gpi) |-> state.lat_rst == RST_CONT)
    else $error("input fault used limited retry");
  chk_unfiltered_fault: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_19
    (!i_cfg[FT_OV].filt_en && i_upd[FT_OV] && i_flt[FT_OV] && !state.fnow[FT_OV])
    |=> (state.status[FT_OV] && state.event_p))
    else $error("unfiltered fault not taken at once");
  chk_shut_now: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE_04
    (|confirm && i_cfg[ft].act == ACT_SHUT_NOW && state.mode == M_ON) |=> (!state.en && state.fault_shut))
    else $error("immediate shutdown missed");
endmodule

// ### verif/conv_model.sv
`timescale 1ns/10ps
module conv_model import rail_fault_pkg::*; (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  // converter side
  input  wire conv_req_s        i_req,
  input  wire logic [ADC_W-1:0] i_data,
  output conv_res_s             o_res
);
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_res <= '0;
    end else begin
      o_res.valid <= i_req.valid;
      o_res.kind  <= i_req.kind;
      o_res.chan  <= i_req.chan;
      o_res.data  <= i_req.valid ? i_data : ~o_res.data;
    end
  end
endmodule

// ### verif/rail_fault_manager_tb.sv
`timescale 1ns/10ps
module rail_fault_manager_tb import rail_fault_pkg::*;;
  logic                                clk_sys = 1'b0;
  logic                                rst_n = 1'b0;
  logic [NUM_RAILS-1:0]                general_input_pin = '0;
  logic [NUM_RAILS-1:0]                pin_en = '0;
  logic [NUM_RAILS-1:0]                on_cmd = '0;
  logic [NUM_RAILS-1:0][NUM_RAILS-1:0] slave = '0;
  logic [2:0]                          clr = '0;
  logic [ADC_W-1:0]                    adc_val = '0;
  logic [ADC_W-1:0]                    ov0;
  fault_cfg_s [NUM_FT-1:0]             cfg;
  rail_limit_s [NUM_RAILS-1:0]         lim;
  rail_ctl_s [NUM_RAILS-1:0]           ctl;
  conv_req_s                           req;
  conv_res_s                           res;
  logic [NUM_RAILS-1:0]                en;
  logic [NUM_DIGITAL_MONITOR_INPUT-1:0]                 digital_monitor_input = 8'hFF;
  logic [NUM_RAILS-1:0]                rsq;
  log_s                                lg;
  logic                                alert_n;
  logic [NUM_RAILS-1:0][NUM_FT-1:0]    st;
  int                                  error_cnt = 0;
  int                                  n_checks = 0;
  int                                  k;
  always #50 clk_sys = ~clk_sys;
  rail_fault_manager #(.T_SLOT_CYC_P(50)) i_rail_fault_manager (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_gpi(general_input_pin), .i_digital_monitor_input(digital_monitor_input), .o_conv(req), .i_conv(res), .i_fault_cfg(cfg), .i_limits(lim),
    .i_rail_ctl(ctl), .i_input_fault_enable(pin_en), .i_slave_mask(slave), .i_restart_gap(16'h0001),
    .i_on_cmd(on_cmd), .i_fault_clr(clr[0]), .i_status_clr(clr[1]), .i_alert_clr(clr[2]), .o_en(en),
    .o_alert_n(alert_n), .o_log(lg), .o_status(st), .o_reseq_wait(rsq));
  conv_model i_conv_model (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_req(req), .i_data(adc_val), .o_res(res));
  function automatic logic ov_hit(input logic [ADC_W-1:0] d, input logic [ADC_W-1:0] lim_v);
    return d > lim_v;
  endfunction
  task automatic chk(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    for (k = 0; k < NUM_FT; k++) begin
      cfg[k] = '{1'b0, 16'h0000, ACT_SHUT_NOW, RST_NONE, 4'h0, 1'b0};
    end
    for (k = 0; k < NUM_RAILS; k++) begin
      lim[k] = '{12'hFFF, 12'h000, 12'hFFF, 12'hFFF};
      ctl[k] = '{1'b1, 1'b1, 1'b1, 16'h0000, 16'h0000, 16'hFFFF};
    end
    k = $urandom(25);
    ov0 = 12'(($urandom % 4093) + 1);
    lim[0].ov = ov0;
    pin_en[3] = 1'b1;
    slave[3][5] = 1'b1;
    cyc(5);
    rst_n = 1'b1;
    cyc(1);
    chk(alert_n, 1'b1, "alert idle");
    on_cmd = 32'h0000_0038;
    cyc(1);
    on_cmd = '0;
    cyc(4);
    chk(en[3], 1'b1, "rail 3 on");
    general_input_pin[4:3] = 2'b11;
    cyc(7);
    chk(lg.valid && lg.rail == 5'h03 && lg.ftype == 3'(FT_GPI), 1'b1, "log entry");
    cyc(3);
    chk(st[4][FT_GPI], 1'b0, "pin 4 status");
    chk(en[4], 1'b1, "rail 4 kept");
    chk(st[3][FT_GPI], 1'b1, "pin 3 status");
    chk(alert_n, 1'b0, "alert");
    chk(en[3], 1'b0, "rail 3 shut");
    chk(en[5], 1'b0, "slave shut");
    general_input_pin = '0;
    cyc(40);
    chk(en[3], 1'b0, "rail 3 stays off");
    on_cmd[3] = 1'b1;
    cyc(1);
    on_cmd = '0;
    cyc(4);
    chk(en[3], 1'b1, "rail 3 back");
    cfg[FT_GPI].reseq = 1'b1;
    pin_en[4] = 1'b1;
    general_input_pin[4] = 1'b1;
    cyc(12);
    chk(rsq[4], 1'b1, "rail 4 held");
    chk(en[4], 1'b0, "rail 4 shut");
    general_input_pin = '0;
    cyc(12);
    chk(rsq[4], 1'b0, "re-sequence started");
    chk(en[4], 1'b1, "rail 4 resequenced");
    clr = 3'b110;
    cyc(1);
    clr = '0;
    cyc(2);
    chk(alert_n, 1'b1, "alert cleared");
    chk(st[3][FT_GPI], 1'b0, "status cleared");
    adc_val = ov0 + 12'h001;
    lim[1].ov = ov0;
    digital_monitor_input[0] = 1'b0;
    for (k = 0; k < 6000 && st[0][FT_OV] !== 1'b1; k++) begin
      cyc(1);
    end
    chk(st[0][FT_OV], ov_hit(adc_val, ov0), "rail 0 ov");
    cyc(130);
    chk(st[1][FT_OV], ov_hit(adc_val, lim[1].ov), "rail 1 ov");
    for (k = 0; k < 4000 && st[24][FT_UV] !== 1'b1; k++) begin
      cyc(1);
    end
    chk(st[24][FT_UV], !digital_monitor_input[0], "digital monitor uv");
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish();
  end
endmodule
